/* shared/rx_cfg_pkg.sv */
// constants for the receive configuration latches, framer and decoder
package rx_cfg_pkg;
	localparam int NUM_BANKS = 16;
	localparam int NUM_CHAN = 4;
	// latch bank numbers per channel: static rx, static tx, dynamic
	localparam logic [3:0] RX_BANK [NUM_CHAN] = '{4'h0, 4'h3, 4'h7, 4'ha};
	localparam logic [3:0] TX_BANK [NUM_CHAN] = '{4'h1, 4'h4, 4'h8, 4'hb};
	localparam logic [3:0] DYN_BANK [NUM_CHAN] = '{4'h2, 4'h5, 4'h9, 4'hc};
	localparam logic [3:0] GLOBAL_DYN_ADDR = 4'he;
	// field positions inside a static receiver bank
	localparam int RF_MODE_LSB = 1;
	localparam int FRAME_CHAR_BIT = 3;
	localparam int DEC_MODE_BIT = 4;
	localparam int DEC_BYP_BIT = 5;
	localparam int RX_CKSEL_BIT = 6;
	localparam int RX_RATE_BIT = 7;
	// reset values: reframe 10, all single-bit selects 1
	localparam logic [7:0] RX_BANK_RESET = 8'hfd;
	localparam logic [7:0] OTHER_BANK_RESET = 8'h00;
	// reframe modes
	localparam logic [1:0] RF_LOW_LATENCY = 2'h0;
	localparam logic [1:0] RF_QUAD = 2'h1;
	localparam logic [1:0] RF_PAIR = 2'h2;
	localparam logic [1:0] RF_TEST = 2'h3;
	// framing patterns, bit 0 is the first bit received (a)
	localparam logic [9:0] K285_NEG = 10'h17c;
	localparam logic [9:0] K285_POS = 10'h283;
	localparam logic [9:0] COMMA_MASK = 10'h0ff;
	localparam logic [3:0] LAST_BIT = 4'h9;
	localparam logic [5:0] CHAR_BITS = 6'h0a;
	localparam logic [2:0] QUAD_RUN = 3'h4;
	localparam logic [5:0] PAIR_SPAN = 6'h32;
	// receive status codes with the decoder enabled
	localparam logic [2:0] ST_DATA = 3'h0;
	localparam logic [2:0] ST_SPECIAL = 3'h1;
	localparam logic [2:0] ST_COMMA = 3'h2;
	// apb map: banks at index*4, status word after them
	localparam logic [4:0] STATUS_IDX = 5'h10;
	localparam int FIFO_DEPTH = 32;
	localparam int OUT_W = 11;
	// 6b and 4b decode tables, index msb is the earliest bit
	localparam logic [5:0] K28_NEG6 = 6'h0f;
	localparam logic [5:0] K28_POS6 = 6'h30;
	localparam logic [4:0] DEC6 [64] = '{
		5'd0, 5'd0, 5'd0, 5'd0, 5'd0, 5'd23, 5'd8, 5'd7,
		5'd0, 5'd27, 5'd4, 5'd20, 5'd24, 5'd12, 5'd28, 5'd28,
		5'd0, 5'd29, 5'd2, 5'd18, 5'd31, 5'd10, 5'd26, 5'd15,
		5'd0, 5'd6, 5'd22, 5'd16, 5'd14, 5'd1, 5'd30, 5'd0,
		5'd0, 5'd30, 5'd1, 5'd17, 5'd16, 5'd9, 5'd25, 5'd0,
		5'd15, 5'd5, 5'd21, 5'd31, 5'd13, 5'd2, 5'd29, 5'd0,
		5'd28, 5'd3, 5'd19, 5'd24, 5'd11, 5'd4, 5'd27, 5'd0,
		5'd7, 5'd8, 5'd23, 5'd0, 5'd0, 5'd0, 5'd0, 5'd0};
	localparam logic [2:0] DEC4 [16] = '{
		3'd0, 3'd7, 3'd4, 3'd3, 3'd0, 3'd2, 3'd6, 3'd7,
		3'd7, 3'd1, 3'd5, 3'd0, 3'd3, 3'd4, 3'd7, 3'd0};
endpackage

/* src/rx_cfg.sv */
// receive framer, decoder and configuration latch banks with apb view
//
// Operation
// - three latch banks per channel, two static
// - static rx banks at 0, 3, 7, 10
// - static tx banks at 1, 4, 8, 11
// - dynamic banks at 2, 5, 9, 12
// - address 1110 with strobe low drives dynamics
// - strobe low latches data into addressed bank
// - reframe mode resets to 10
// - mode 00 realigns on every framing character
// - mode 01 needs four adjacent aligned characters
// - mode 10 needs aligned pair within 50 bits
// - framing select resets 1, K28.5 or comma
// - decode mode resets 1, picks special column
// - bypass bit resets 1, 0 passes raw
// - clock select resets 1, reference or recovered
// - output clock at full or half rate
// - bypassed detect flag marks framing character
// - rate bit resets 1, 1 is half rate
`timescale 1ns/1ps

// character fifo between the recovered and output timing
module char_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_t;
	fifo_t s_r;
	fifo_t s_nxt;
	logic push;
	logic pop;

	// full and empty come straight from the occupancy count
	assign in_ready = (s_r.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_r.cnt != '0);
	assign out_data = s_r.mem[s_r.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data;
			s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
		end
		if (pop)
			s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
		s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule // char_fifo

// one receive channel datapath plus the sixteen latch banks
module rx_cfg
	import rx_cfg_pkg::*;
#(
	parameter int DATA_CHAN = 0,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] config_addr,
	input wire logic [7:0] config_data,
	input wire logic config_write_strobe_n,
	input wire logic rx_serial_bit,
	input wire logic reference_clock_in,
	output logic [7:0] rx_data,
	output logic [2:0] rx_status,
	output logic rx_out_valid,
	output logic framing_char_detected,
	output logic receive_clock_out,
	output logic [31:0] tx_ctrl,
	output logic [31:0] dyn_ctrl,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	typedef struct packed {
		logic [NUM_BANKS-1:0][7:0] banks;
		logic [19:0] sr;
		logic [3:0] bit_cnt;
		logic [3:0] align;
		logic [3:0] cand;
		logic [2:0] cand_cnt;
		logic [5:0] since;
		logic locked;
		logic ref_d;
		logic [7:0] out_data;
		logic [2:0] out_st;
		logic out_valid;
		logic rclk;
		logic ovf;
		logic [31:0] prdata;
	} state_t;
	state_t s_r;
	state_t s_nxt;

	logic [7:0] rx_bank;
	logic [1:0] rf_mode;
	logic frame_sel;
	logic dec_mode;
	logic dec_en;
	logic src_ref;
	logic half_rate;
	logic [9:0] newest;
	logic hit;
	logic emit;
	logic [3:0] cur;
	logic [OUT_W-1:0] push_word;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [OUT_W-1:0] fifo_out;
	logic pop;
	logic ref_rise;
	logic [4:0] apb_idx;
	logic apb_map;

	// the datapath channel takes its settings from its static rx bank
	assign rx_bank = s_r.banks[RX_BANK[DATA_CHAN]];
	assign rf_mode = rx_bank[RF_MODE_LSB +: 2];
	assign frame_sel = rx_bank[FRAME_CHAR_BIT];
	assign dec_mode = rx_bank[DEC_MODE_BIT];
	assign dec_en = rx_bank[DEC_BYP_BIT];
	assign src_ref = rx_bank[RX_CKSEL_BIT];
	assign half_rate = rx_bank[RX_RATE_BIT];

	// static tx and dynamic banks leave the block for the other paths
	generate
		for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
			assign tx_ctrl[8*c +: 8] = s_r.banks[TX_BANK[c]];
			assign dyn_ctrl[8*c +: 8] = s_r.banks[DYN_BANK[c]];
		end
	endgenerate

	// framing match on the ten newest bits, either disparity
	assign newest = s_r.sr[19:10];
	always_comb begin
		if (frame_sel)
			hit = (newest == K285_NEG) || (newest == K285_POS);
		else
			hit = ((newest & COMMA_MASK) == (K285_NEG & COMMA_MASK)) ||
				((newest & COMMA_MASK) == (K285_POS & COMMA_MASK));
	end
	assign cur = s_r.bit_cnt;

	// decode or bypass, packed as {rxd[7:0], rxst[2:0]}
	always_comb begin
		logic [5:0] i6;
		logic [3:0] i4;
		logic [2:0] y;
		logic is_k;
		i6 = {newest[0], newest[1], newest[2], newest[3], newest[4],
			newest[5]};
		i4 = {newest[6], newest[7], newest[8], newest[9]};
		y = (i6 == K28_POS6) ? DEC4[~i4] : DEC4[i4];
		is_k = (i6 == K28_NEG6) || (i6 == K28_POS6) ||
			(((i4 == 4'h8) || (i4 == 4'h7)) &&
			((DEC6[i6] == 5'd23) || (DEC6[i6] == 5'd27) ||
			(DEC6[i6] == 5'd29) || (DEC6[i6] == 5'd30)));
		if (!dec_en)
			push_word = {newest[9:2], newest[0], newest[1], hit};
		else if (is_k && hit && dec_mode)
			push_word = {y, DEC6[i6], ST_COMMA};
		else if (is_k)
			push_word = {y, DEC6[i6], ST_SPECIAL};
		else
			push_word = {y, DEC6[i6], ST_DATA};
	end

	// output registers move on rising reference edges or as soon as data is ready
	assign ref_rise = reference_clock_in && !s_r.ref_d;
	assign pop = fifo_out_valid && (src_ref ? ref_rise : 1'b1);

	// apb decode: word index from byte address, status after the banks
	assign apb_idx = paddr[6:2];
	assign apb_map = (paddr[31:7] == '0) && (paddr[1:0] == 2'h0) &&
		(apb_idx <= STATUS_IDX);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !apb_map;
	assign prdata = s_r.prdata;

	// next state: latches, framer, output stage and apb read data
	always_comb begin
		s_nxt = s_r;
		emit = 1'b0;
		s_nxt.sr = {rx_serial_bit, s_r.sr[19:1]};
		s_nxt.bit_cnt = (s_r.bit_cnt == LAST_BIT) ? '0 : s_r.bit_cnt + 1'b1;
		s_nxt.since = (s_r.since == '1) ? s_r.since : s_r.since + 1'b1;
		s_nxt.ref_d = reference_clock_in;
		if (hit) begin
			s_nxt.cand = cur;
			s_nxt.since = 6'h01;
			case (rf_mode)
				RF_LOW_LATENCY: begin
					// truncate: the boundary jumps to this character at once, so the gap since the last emit is cut short
					s_nxt.align = cur;
					s_nxt.locked = 1'b1;
				end
				RF_QUAD: begin
					if (cur == s_r.cand && s_r.since == CHAR_BITS)
						s_nxt.cand_cnt = s_r.cand_cnt + 1'b1;
					else
						s_nxt.cand_cnt = 3'h1;
					if (s_nxt.cand_cnt == QUAD_RUN) begin
						s_nxt.align = cur;
						s_nxt.locked = 1'b1;
						s_nxt.cand_cnt = '0;
					end
				end
				RF_PAIR: begin
					// equal bit phase means the same 10-bit boundary
					if (cur == s_r.cand && s_r.since <= PAIR_SPAN) begin
						s_nxt.align = cur;
						s_nxt.locked = 1'b1;
					end
				end
				default: begin
					// test encoding: the framer holds its boundary
					s_nxt.cand = s_r.cand;
				end
			endcase
		end
		// a full fifo drops the character and flags it, the line cannot wait
		emit = (cur == s_nxt.align);
		if (emit && !fifo_in_ready)
			s_nxt.ovf = 1'b1;
		s_nxt.out_valid = pop;
		if (pop) begin
			s_nxt.out_data = fifo_out[OUT_W-1:3];
			s_nxt.out_st = fifo_out[2:0];
			// half rate toggles per character, full rate pulses per char
			s_nxt.rclk = half_rate ? !s_r.rclk : 1'b1;
		end else if (!half_rate) begin
			s_nxt.rclk = 1'b0;
		end
		// apb reads are fetched in setup so the access cycle has no wait
		if (psel && !penable) begin
			if (!apb_map)
				s_nxt.prdata = '0;
			else if (apb_idx == STATUS_IDX)
				s_nxt.prdata = {26'h0, s_r.align, s_r.locked, s_r.ovf};
			else
				s_nxt.prdata = {24'h0, s_r.banks[apb_idx[3:0]]};
		end
		if (psel && penable && pwrite && apb_map) begin
			if (apb_idx == STATUS_IDX) begin
				// a drop in the same cycle keeps the flag set
				if (pwdata[0] && !(emit && !fifo_in_ready))
					s_nxt.ovf = 1'b0;
			end else begin
				s_nxt.banks[apb_idx[3:0]] = pwdata[7:0];
			end
		end
		// pin writes come last so they win over a colliding apb write
		if (!config_write_strobe_n) begin
			if (config_addr == GLOBAL_DYN_ADDR) begin
				for (int c = 0; c < NUM_CHAN; c++)
					s_nxt.banks[DYN_BANK[c]] = config_data;
			end
			s_nxt.banks[config_addr] = config_data;
		end
	end

	// all state resets to constants; rx banks to their documented defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			for (int b = 0; b < NUM_BANKS; b++)
				s_r.banks[b] <= OTHER_BANK_RESET;
			for (int c = 0; c < NUM_CHAN; c++)
				s_r.banks[RX_BANK[c]] <= RX_BANK_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	char_fifo #(.WIDTH(OUT_W), .DEPTH(DEPTH)) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(emit),
		.in_ready(fifo_in_ready),
		.in_data(push_word),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out)
	);

	assign rx_data = s_r.out_data;
	assign rx_status = s_r.out_st;
	assign rx_out_valid = s_r.out_valid;
	assign framing_char_detected = s_r.out_st[0] && !dec_en;
	assign receive_clock_out = s_r.rclk;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_reset_defaults: assert property ($rose(presetn) |->
		rf_mode == RF_PAIR && frame_sel && dec_mode && dec_en &&
		src_ref && half_rate)
		else $error("receive bank defaults wrong after reset");
	chk_pin_write: assert property (!config_write_strobe_n &&
		config_addr != GLOBAL_DYN_ADDR |=>
		s_r.banks[$past(config_addr)] == $past(config_data))
		else $error("strobe write not latched");
	chk_global_dyn: assert property (!config_write_strobe_n &&
		config_addr == GLOBAL_DYN_ADDR |=>
		dyn_ctrl == {4{$past(config_data)}})
		else $error("global dynamic write missed a channel");
	chk_lowlat_align: assert property (rf_mode == RF_LOW_LATENCY &&
		hit |-> emit ##1 s_r.align == $past(cur))
		else $error("low latency framer did not realign");
	chk_quad_run: assert property (rf_mode == RF_QUAD &&
		s_nxt.align != s_r.align |->
		s_r.cand_cnt == 3'h3 && s_r.since == CHAR_BITS && hit)
		else $error("quad framer realigned without four matches");
	chk_pair_span: assert property (rf_mode == RF_PAIR &&
		s_nxt.align != s_r.align |-> hit && s_r.since <= PAIR_SPAN &&
		cur == s_r.cand)
		else $error("pair framer realigned outside span");
	chk_test_hold: assert property (rf_mode == RF_TEST |=>
		s_r.align == $past(s_r.align))
		else $error("boundary moved in test mode");
	chk_ref_source: assert property (pop && src_ref |->
		reference_clock_in && !s_r.ref_d ##1 rx_out_valid)
		else $error("output loaded off a reference edge");
	chk_half_rate: assert property (pop && half_rate |=>
		receive_clock_out != $past(receive_clock_out))
		else $error("half rate clock did not toggle");
	chk_bypass_flag: assert property (pop && !dec_en |=>
		framing_char_detected == $past(fifo_out[0]))
		else $error("framing detect flag wrong in bypass");
	// a drop must leave the sticky flag set, even against a clear
	chk_overflow_set: assert property (emit && !fifo_in_ready |=>
		s_r.ovf)
		else $error("dropped character did not set overflow");

	cov_pair_realign: cover property (rf_mode == RF_PAIR &&
		s_nxt.align != s_r.align);
	cov_quad_realign: cover property (rf_mode == RF_QUAD &&
		s_nxt.align != s_r.align);
	cov_overflow: cover property (emit && !fifo_in_ready);
	cov_bypass_detect: cover property (framing_char_detected);
	cov_global_write: cover property (!config_write_strobe_n &&
		config_addr == GLOBAL_DYN_ADDR);
endmodule // rx_cfg

/* verification/serial_tx_model.sv */
// remote serial transmitter model: sends 10-bit characters, bit a first
`timescale 1ns/1ps

module serial_tx_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [9:0] char_data,
	input wire logic char_slip,
	output logic char_ready,
	output logic rx_serial_bit
);
	logic [10:0] sh_r;
	logic [3:0] cnt_r;
	logic [3:0] last_r;

	// the next character is taken at the edge where ready is high
	assign char_ready = (cnt_r == last_r);
	assign rx_serial_bit = sh_r[0];

	// a slip sends one extra bit first, so the boundary moves by one bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_r <= 11'h155;
			cnt_r <= 4'h0;
			last_r <= 4'h9;
		end else if (char_ready) begin
			sh_r <= char_slip ? {char_data, 1'b1} : {1'b0, char_data};
			cnt_r <= 4'h0;
			last_r <= char_slip ? 4'ha : 4'h9;
		end else begin
			sh_r <= {1'b0, sh_r[10:1]};
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule // serial_tx_model

/* verification/test_rx_cfg.sv */
// self-checking bench for the receive framer and configuration banks
`timescale 1ns/1ps

module test_rx_cfg;
	import rx_cfg_pkg::*;
	localparam logic [9:0] FILL = 10'h155;
	localparam logic [9:0] K281_NEG = 10'h27c;
	logic pclk = 1'b0, presetn = 1'b0, reference_clock_in = 1'b0;
	logic config_write_strobe_n = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, char_slip = 1'b0, armed = 1'b0, half = 1'b1;
	logic last_rco = 1'b0, ref_run = 1'b1, byp_on = 1'b0;
	logic [3:0] config_addr = 4'h0;
	logic [7:0] config_data = 8'h00;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, seed = 32'h33;
	logic [9:0] char_data = 10'h155;
	logic rx_serial_bit, char_ready, rx_out_valid, framing_char_detected;
	logic receive_clock_out, pready, pslverr;
	logic [7:0] rx_data;
	logic [2:0] rx_status;
	logic [31:0] tx_ctrl, dyn_ctrl, prdata;
	logic [10:0] out_w, sync_v, sync_m;
	logic [21:0] exp_q[$];
	logic [21:0] e;
	int n_fail = 0;
	int comparisons = 0;
	int n_out = 0;

	rx_cfg #(.DATA_CHAN(0), .DEPTH(FIFO_DEPTH)) i_rx_cfg (
		.pclk(pclk), .presetn(presetn), .config_addr(config_addr),
		.config_data(config_data),
		.config_write_strobe_n(config_write_strobe_n),
		.rx_serial_bit(rx_serial_bit),
		.reference_clock_in(reference_clock_in), .rx_data(rx_data),
		.rx_status(rx_status), .rx_out_valid(rx_out_valid),
		.framing_char_detected(framing_char_detected),
		.receive_clock_out(receive_clock_out), .tx_ctrl(tx_ctrl),
		.dyn_ctrl(dyn_ctrl), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	serial_tx_model i_serial_tx_model (.pclk(pclk), .presetn(presetn),
		.char_data(char_data), .char_slip(char_slip),
		.char_ready(char_ready), .rx_serial_bit(rx_serial_bit));

	// clocks; the reference level stops to stall the output side
	always #10 pclk = ~pclk;
	always @(posedge pclk) if (ref_run) reference_clock_in <= ~reference_clock_in;
	assign out_w = {rx_data, rx_status};

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// bypass expectation: j..c on the data bus, then a, b, detect
	function automatic logic [21:0] byp(input logic [9:0] c, input logic d);
		return {11'h7ff, c[9:2], c[0], c[1], d};
	endfunction

	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		comparisons++;
		if (got !== ex) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// one latch write through the pins, strobe low for one edge
	task automatic cfg(input logic [3:0] a, input logic [7:0] d);
		@(posedge pclk);
		config_addr <= a;
		config_data <= d;
		config_write_strobe_n <= 1'b0;
		@(posedge pclk);
		config_write_strobe_n <= 1'b1;
	endtask

	// hand one character to the far end and note what should come out
	task automatic send(input logic [9:0] c, input logic [21:0] ev,
		input logic sl);
		char_data <= c;
		char_slip <= sl;
		do begin
			@(posedge pclk);
		end while (char_ready !== 1'b1);
		if (ev[21:11] != 11'h0) exp_q.push_back(ev);
	endtask

	// a fresh setup; the first framing character out re-arms the monitor
	task automatic phase(input logic [7:0] cv, input logic [21:0] sv,
		input logic hf);
		@(negedge pclk);
		armed = 1'b0;
		sync_v = sv[10:0];
		sync_m = sv[21:11];
		half = hf;
		byp_on = !cv[5];
		cfg(4'h0, cv);
		repeat (4) send(FILL, 22'h0, 1'b0);
		send(K285_NEG, 22'h0, 1'b0);
	endtask

	task automatic drain();
		repeat (3) send(FILL, 22'h0, 1'b0);
		for (int k = 0; k < 200 && exp_q.size() > 0; k++) @(posedge pclk);
		chk("left_over", 32'h0, 32'(exp_q.size()));
		$display("stream test done");
	endtask

	// slip one bit, then too few and enough framing characters
	task automatic realign(input logic [7:0] cv, input int need);
		logic [31:0] rd;
		logic err;
		logic [3:0] pa;
		cfg(4'h0, cv);
		repeat (2) send(FILL, 22'h0, 1'b0);
		apb(1'b0, 32'h40, 32'h0, rd, err);
		pa = rd[5:2];
		send(FILL, 22'h0, 1'b1);
		repeat (need - 1) send(K285_NEG, 22'h0, 1'b0);
		repeat (6) send(FILL, 22'h0, 1'b0);
		apb(1'b0, 32'h40, 32'h0, rd, err);
		chk("held_phase", {28'h0, pa}, {28'h0, rd[5:2]});
		repeat (need) send(K285_NEG, 22'h0, 1'b0);
		repeat (3) send(FILL, 22'h0, 1'b0);
		apb(1'b0, 32'h40, 32'h0, rd, err);
		pa = (pa == 4'h9) ? 4'h0 : pa + 4'h1;
		chk("new_phase", {28'h0, pa}, {28'h0, rd[5:2]});
		$display("realign test done");
	endtask

	// monitor: compares each loaded character with the oldest note
	always @(posedge pclk) begin
		if (rx_out_valid === 1'b1) begin
			n_out++;
			if (!armed) armed = ((out_w & sync_m) === sync_v);
			else if (exp_q.size() > 0) begin
				e = exp_q.pop_front();
				chk("rx_char", {21'h0, e[10:0]}, {21'h0, out_w & e[21:11]});
				chk("rx_clk", {31'h0, half ? ~last_rco : 1'b1},
					{31'h0, receive_clock_out});
				chk("detect", {31'h0, byp_on & e[0]},
					{31'h0, framing_char_detected});
			end
			last_rco = receive_clock_out;
		end
	end

	// watchdog against a hang
	initial begin
		#400000;
		n_fail++;
		close_out();
	end

	initial begin
		logic [31:0] rd, v, ev;
		logic err;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			apb(1'b0, 32'(4 * i), 32'h0, rd, err);
			ev = (i inside {0, 3, 7, 10}) ? 32'hfd : 32'h0;
			chk("bank_reset", ev, rd);
		end
		apb(1'b0, 32'h44, 32'h0, rd, err);
		chk("unmapped", 32'h1, {31'h0, err});
		$display("reset test done");
		v = rnd();
		cfg(4'h1, v[7:0]);
		cfg(4'h4, v[15:8]);
		cfg(4'h8, v[23:16]);
		cfg(4'hb, v[31:24]);
		cfg(4'h3, 8'h5a);
		@(posedge pclk);
		chk("tx_banks", v, tx_ctrl);
		apb(1'b0, 32'hc, 32'h0, rd, err);
		chk("rx_bank3", 32'h5a, rd);
		@(posedge pclk);
		config_addr <= GLOBAL_DYN_ADDR;
		config_write_strobe_n <= 1'b0;
		repeat (3) begin
			v = rnd();
			config_data <= v[7:0];
			repeat (2) @(posedge pclk);
			chk("global_dyn", {4{v[7:0]}}, dyn_ctrl);
		end
		config_write_strobe_n <= 1'b1;
		ev = rnd();
		apb(1'b1, 32'h14, {24'h0, ev[7:0]}, rd, err);
		@(posedge pclk);
		chk("dyn_bank5", {v[7:0], v[7:0], ev[7:0], v[7:0]}, dyn_ctrl);
		$display("latch test done");
		phase(8'h99, byp(K285_NEG, 1'b1), 1'b1);
		send(K285_POS, byp(K285_POS, 1'b1), 1'b0);
		send(FILL, byp(FILL, 1'b0), 1'b0);
		send(K281_NEG, byp(K281_NEG, 1'b0), 1'b0);
		drain();
		phase(8'h91, byp(K285_NEG, 1'b1), 1'b1);
		send(K281_NEG, byp(K281_NEG, 1'b1), 1'b0);
		send(FILL, byp(FILL, 1'b0), 1'b0);
		drain();
		phase(8'hf9, {11'h007, 8'h0, ST_COMMA}, 1'b1);
		send(FILL, {11'h7ff, 8'hb5, ST_DATA}, 1'b0);
		send(K285_POS, {11'h007, 8'h0, ST_COMMA}, 1'b0);
		drain();
		phase(8'h29, {11'h007, 8'h0, ST_SPECIAL}, 1'b0);
		send(K285_NEG, {11'h007, 8'h0, ST_SPECIAL}, 1'b0);
		send(FILL, {11'h7ff, 8'hb5, ST_DATA}, 1'b0);
		drain();
		realign(8'h99, 1);
		realign(8'h9d, 2);
		realign(8'h9b, 4);
		cfg(4'h0, 8'hd9);
		@(negedge pclk);
		ref_run = 1'b0;
		armed = 1'b0;
		repeat (2) send(FILL, 22'h0, 1'b0);
		v = n_out;
		repeat (40) send(FILL, 22'h0, 1'b0);
		chk("stalled_out", v, 32'(n_out));
		apb(1'b0, 32'h40, 32'h0, rd, err);
		chk("overflow", 32'h1, {31'h0, rd[0]});
		@(negedge pclk);
		ref_run = 1'b1;
		repeat (100) @(posedge pclk);
		apb(1'b1, 32'h40, 32'h1, rd, err);
		apb(1'b0, 32'h40, 32'h0, rd, err);
		chk("ovf_clear", 32'h0, {31'h0, rd[0]});
		chk("drained", 32'h1, {31'h0, (32'(n_out) - v) >= 32});
		$display("buffer test done");
		close_out();
	end
endmodule // test_rx_cfg
